// ===== dv/ext_bus_checker.sv
// Checker: wait, hold and bus request relations at the block's pins.
// Assumes it is bound into the block and sees only its ports.
`timescale 1ns/1ps
module ext_bus_checker
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
)
(
  // Clock and reset
  input wire logic              i_sys_clk,
  input wire logic              i_sys_rst,
  // APB slave
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [11:0]       i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic              o_pready,
  // Core request port
  input wire logic              i_core_req,
  input wire logic [1:0]        i_core_space,
  input wire logic [ADDR_W-1:0] i_core_addr,
  input wire logic              i_core_we,
  input wire logic [DATA_W-1:0] i_core_wdata,
  input wire logic              o_core_ready,
  input wire logic              o_core_done,
  input wire logic              o_core_hold,
  // External bus pins
  input wire logic [ADDR_W-1:0] o_ext_addr,
  input wire logic              o_ext_addr_oe,
  input wire logic              o_ext_data_oe,
  input wire logic              o_ext_ctrl_oe,
  input wire logic              o_ext_strobe_n,
  input wire logic              o_ext_prog_sel_n,
  input wire logic              o_ext_data_sel_n,
  input wire logic              o_ext_io_sel_n,
  input wire logic              i_hold_n,
  input wire logic              o_hold_acknowledge_n,
  input wire logic              o_global_bus_request_n
);
  logic [11:0] wsc_ff;
  logic [3:0]  low_cnt_ff;
  logic [2:0]  cur_n;
  logic        port_wr;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  assign port_wr = i_core_req && o_core_ready && i_core_we &&
                   i_core_space == 2'h2 && i_core_addr == 16'hFFFF;

  // Shadow of the wait register; the port write wins a tie
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    if (i_sys_rst)
      wsc_ff <= 12'hFFF;
    else if (port_wr)
      wsc_ff <= i_core_wdata[11:0];
    else if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == 0)
      wsc_ff <= i_pwdata[11:0];

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    if (i_sys_rst)
      low_cnt_ff <= 4'h0;
    else
      low_cnt_ff <= o_ext_strobe_n ? 4'h0 : low_cnt_ff + 4'h1;

  always_comb
    if (!o_ext_prog_sel_n)
      cur_n = o_ext_addr[15] ? wsc_ff[5:3] : wsc_ff[2:0];
    else if (!o_ext_data_sel_n)
      cur_n = wsc_ff[8:6];
    else if (!o_ext_io_sel_n)
      cur_n = wsc_ff[11:9];
    else
      cur_n = 3'h0;

  a_wait_floor: assert property (
    $rose(o_ext_strobe_n) |-> low_cnt_ff > {1'b0, $past(cur_n)})
    else $error("strobe shorter than programmed waits");
  a_done_at_end: assert property (
    $rose(o_ext_strobe_n) |-> o_core_done)
    else $error("access ended without done");
  a_hold_float: assert property (
    !o_hold_acknowledge_n |->
      !(o_ext_addr_oe || o_ext_ctrl_oe || o_ext_data_oe))
    else $error("bus driven while hold acknowledged");
  a_hold_cause: assert property (
    $fell(o_hold_acknowledge_n) |-> !$past(i_hold_n, 2))
    else $error("hold acknowledged without request");
  a_hold_status: assert property (
    (o_core_hold == !o_hold_acknowledge_n) &&
    (o_hold_acknowledge_n || (o_ext_strobe_n && !o_core_ready)))
    else $error("hold status mismatch");
  a_hold_leave: assert property (
    $rose(i_hold_n) |-> ##[1:6] o_hold_acknowledge_n)
    else $error("hold not left in time");
  a_req_data: assert property (
    !o_global_bus_request_n |-> !o_ext_data_sel_n)
    else $error("bus request outside data access");
  a_port_write: assert property (
    port_wr |=> o_core_done && o_ext_strobe_n)
    else $error("port write not done at once");
endmodule : ext_bus_checker

bind ext_bus_wait_state_control ext_bus_checker
  #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) ext_bus_checker_i (.*);

// ===== dv/ext_mem_model.sv
// External memory and bus master model for the wait-state block.
// Assumes the block's external pins; slow and take_bus come from the bench.
`timescale 1ns/1ps
module ext_mem_model
(
  input  wire logic        i_clk,
  input  wire logic        i_strobe_n,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_slow,
  input  wire logic        i_take_bus,
  output logic             o_ready,
  output logic      [15:0] o_data,
  output logic             o_hold_n
);
  logic [3:0] stall;
  logic       strobe_q;

  initial
  begin
    o_ready  = 1'b1;
    o_data   = 16'h0000;
    o_hold_n = 1'b1;
    stall    = 4'h0;
    strobe_q = 1'b1;
  end

  always @(posedge i_clk)
  begin
    strobe_q <= i_strobe_n;
    o_hold_n <= !i_take_bus;
    // Released bus shows a changing pattern, not the last word
    o_data <= !i_strobe_n ? i_addr ^ 16'hA5A5 : ~o_data;
    if (!i_strobe_n && strobe_q && i_slow)
    begin
      stall   <= 4'h6;
      o_ready <= 1'b0;
    end
    else if (stall != 4'h0)
    begin
      stall   <= stall - 4'h1;
      o_ready <= stall == 4'h1;
    end
  end
endmodule : ext_mem_model

// ===== dv/tb_top.sv
// Self-checking bench for the wait-state block.
// Assumes the checker is bound in and the memory model sits on the pins.
`timescale 1ns/1ps
module tb_top;
  logic i_sys_clk, i_sys_rst, i_psel, i_penable, i_pwrite, o_pready;
  logic o_pslverr, i_core_req, i_core_we, o_core_ready, o_core_done;
  logic o_core_hold, o_ext_addr_oe, o_ext_data_oe, o_ext_strobe_n;
  logic o_ext_read, o_ext_prog_sel_n, o_ext_data_sel_n, o_ext_io_sel_n;
  logic o_ext_ctrl_oe, i_ready, i_hold_n, o_hold_acknowledge_n;
  logic o_global_bus_request_n, slow, take_bus, req_seen, seen_write;
  logic [2:0]  seen_sel;
  logic [15:0] seen_addr, seen_wdata;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [1:0]  i_core_space;
  logic [15:0] i_core_addr, i_core_wdata, o_core_rdata, o_ext_addr;
  logic [15:0] i_ext_data, o_ext_data;
  logic        err;
  int          n_errors, checks, cycles, lat;

  ext_bus_wait_state_control ext_bus_wait_state_control_i (.*);
  ext_mem_model ext_mem_model_i (.i_clk(i_sys_clk),
    .i_strobe_n(o_ext_strobe_n), .i_addr(o_ext_addr), .i_slow(slow),
    .i_take_bus(take_bus), .o_ready(i_ready), .o_data(i_ext_data),
    .o_hold_n(i_hold_n));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // Pins seen in mid-cycle while an access strobe is low
  always @(negedge i_sys_clk)
  begin
    if (o_global_bus_request_n === 1'b0)
      req_seen = 1'b1;
    if (o_ext_strobe_n === 1'b0)
    begin
      seen_addr  = o_ext_addr;
      seen_wdata = o_ext_data;
      seen_write = o_ext_data_oe && !o_ext_read;
      seen_sel   = {o_ext_prog_sel_n, o_ext_data_sel_n, o_ext_io_sel_n};
    end
  end

  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge i_sys_clk);
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= a;
    i_pwdata <= wd;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1)
      @(posedge i_sys_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // Latency counts cycles from the accept edge to the done pulse
  task automatic core(input logic [1:0] sp, input logic [15:0] a,
                      input logic we);
    @(posedge i_sys_clk);
    i_core_req   <= 1'b1;
    i_core_space <= sp;
    i_core_addr  <= a;
    i_core_we    <= we;
    i_core_wdata <= 16'hF000;
    do
      @(negedge i_sys_clk);
    while (o_core_ready !== 1'b1);
    @(posedge i_sys_clk);
    i_core_req <= 1'b0;
    lat = 0;
    do
    begin
      @(negedge i_sys_clk);
      lat++;
    end
    while (o_core_done !== 1'b1 && lat < 100);
  endtask : core

  task automatic t_waits();
    logic [1:0]  sp_t[4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    logic [15:0] ad_t[4] = '{16'h7FFF, 16'h8000, 16'h0200, 16'h0010};
    logic [2:0]  sl_t[4] = '{3'h3, 3'h3, 3'h5, 3'h6};
    core(2'h2, 16'h0010, 1'b0);
    check("reset_waits", lat, 9);
    for (int n = 0; n < 8; n++)
    begin
      apb(1'b1, 12'h000, 32'h0000F000 | (n << 6));
      core(2'h1, 16'h0200, 1'b1);
      check("data_waits", lat, n + 2);
      check("write_addr", seen_addr, 16'h0200);
      check("write_data", seen_wdata, 16'hF000);
      check("write_dir", seen_write, 1);
    end
    apb(1'b1, 12'h000, 32'h000008D1);
    for (int i = 0; i < 4; i++)
    begin
      core(sp_t[i], ad_t[i], 1'b0);
      check("space_waits", lat, i + 3);
      check("space_sel", seen_sel, sl_t[i]);
    end
    core(2'h3, 16'h0010, 1'b0);
    check("spare_space_waits", lat, 2);
    check("spare_space_sel", seen_sel, 3'h7);
    core(2'h2, 16'hFFFF, 1'b1);
    check("port_write", lat, 1);
    core(2'h2, 16'h0010, 1'b0);
    check("port_waits", lat, 2);
    check("read_dir", seen_write, 0);
    check("read_addr", seen_addr, 16'h0010);
  endtask : t_waits

  task automatic t_slow_global();
    apb(1'b1, 12'h000, 32'h000000C0);
    slow <= 1'b1;
    core(2'h1, 16'h0400, 1'b0);
    check("stretch", lat > 5, 1);
    check("slow_rdata", o_core_rdata, 16'hA1A5);
    slow <= 1'b0;
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check("region_size", rd, 32'h1);
    req_seen = 1'b0;
    core(2'h1, 16'hFF10, 1'b0);
    check("req_inside", req_seen, 1);
    req_seen = 1'b0;
    core(2'h0, 16'hFF10, 1'b0);
    core(2'h1, 16'h1000, 1'b0);
    check("req_outside", req_seen, 0);
  endtask : t_slow_global

  // Hold is asked for while a data read is under way; the read must finish
  task automatic t_hold();
    fork
      core(2'h1, 16'h0200, 1'b0);
      begin
        @(posedge i_sys_clk);
        take_bus <= 1'b1;
      end
    join
    check("hold_after_access", lat, 5);
    for (int i = 0; i < 10 && o_hold_acknowledge_n !== 1'b0; i++)
      @(negedge i_sys_clk);
    check("hold_float", {o_ext_addr_oe, o_ext_ctrl_oe}, 0);
    check("core_hold", o_core_hold, 1);
    apb(1'b0, 12'h008, 32'h0);
    check("hold_status", rd[1], 1);
    take_bus <= 1'b0;
    for (int i = 0; i < 10 && o_hold_acknowledge_n !== 1'b1; i++)
      @(negedge i_sys_clk);
    check("hold_exit", o_hold_acknowledge_n, 1);
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped", err, 1);
  endtask : t_hold

  initial
  begin
    i_sys_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_core_req = 1'b0;
    i_core_space = 2'h0;
    i_core_addr = 16'h0;
    i_core_we = 1'b0;
    i_core_wdata = 16'h0;
    slow = 1'b0;
    take_bus = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_waits();
    t_slow_global();
    t_hold();
    print_verdict();
  end
endmodule : tb_top

// ===== hw/ext_bus_consts.svh
// Offsets, field positions, reset values and codes for the external bus
// control block. Included by the block's package users; definitions only.
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH

// APB register byte offsets
`define WSC_OFFSET        12'h000
`define GRS_OFFSET        12'h004
`define STAT_OFFSET       12'h008

// Wait-state register fields, low bit of each 3-bit count
`define WSC_LOW_PROG_LSB  0
`define WSC_HIGH_PROG_LSB 3
`define WSC_DATA_LSB      6
`define WSC_IO_LSB        9
`define WSC_USED_BITS     12
`define WSC_RESET         12'hFFF

// Global region size register
`define GRS_RESET         8'h00

// I/O port that reaches the wait-state register
`define WSC_IO_PORT       16'hFFFF

// Address bit splitting program space into halves
`define PROG_HALF_BIT     15

// Space codes on the core request port
`define SPACE_PROG        2'h0
`define SPACE_DATA        2'h1
`define SPACE_IO          2'h2

// Status register bit positions
`define STAT_BUSY         0
`define STAT_HOLD_ACK     1
`define STAT_READY        2
`define STAT_GLOBAL       3

`endif

// ===== hw/ext_bus_pkg.sv
// Types shared by the external bus control block and its wait counter.
// Assumes the constants header is included by the design files.
package ext_bus_pkg;

  typedef enum {
    ST_IDLE,
    ST_ACCESS,
    ST_HOLD
  } bus_state_t;

  typedef logic [2:0] wait_cnt_t;

endpackage : ext_bus_pkg

// ===== hw/ext_bus_wait_state_control.sv
// External memory interface control: wait states, global region, hold.
// Assumes a core request port on i_sys_clk, external pins asynchronous
// to it, and an APB master for the configuration registers.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "ext_bus_consts.svh"
module ext_bus_wait_state_control
  import ext_bus_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
)
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Core request port
  input  wire logic              i_core_req,
  input  wire logic [1:0]        i_core_space,
  input  wire logic [ADDR_W-1:0] i_core_addr,
  input  wire logic              i_core_we,
  input  wire logic [DATA_W-1:0] i_core_wdata,
  output logic                   o_core_ready,
  output logic                   o_core_done,
  output logic      [DATA_W-1:0] o_core_rdata,
  output logic                   o_core_hold,
  // External bus pins
  output logic      [ADDR_W-1:0] o_ext_addr,
  output logic                   o_ext_addr_oe,
  input  wire logic [DATA_W-1:0] i_ext_data,
  output logic      [DATA_W-1:0] o_ext_data,
  output logic                   o_ext_data_oe,
  output logic                   o_ext_strobe_n,
  output logic                   o_ext_read,
  output logic                   o_ext_prog_sel_n,
  output logic                   o_ext_data_sel_n,
  output logic                   o_ext_io_sel_n,
  output logic                   o_ext_ctrl_oe,
  input  wire logic              i_ready,
  input  wire logic              i_hold_n,
  output logic                   o_hold_acknowledge_n,
  output logic                   o_global_bus_request_n
);

  //----------------------------------------------------------------
  // Elaboration checks
  //----------------------------------------------------------------
  // The space split and the region decode assume a 64K word space
  if (ADDR_W != 16)
    $error("ADDR_W must be 16");
  if (DATA_W < `WSC_USED_BITS || DATA_W > 32)
    $error("DATA_W must be 12 to 32");

  //----------------------------------------------------------------
  // Functions
  //----------------------------------------------------------------
  function automatic wait_cnt_t sel_wait(
    input logic [1:0]                      space,
    input logic [ADDR_W-1:0]               addr,
    input logic [`WSC_USED_BITS-1:0]       wsc
  );
    wait_cnt_t w;
    w = 3'h0;
    case (space)
      `SPACE_PROG:
        if (!addr[`PROG_HALF_BIT])
          w = wsc[`WSC_LOW_PROG_LSB +: 3];
        else
          w = wsc[`WSC_HIGH_PROG_LSB +: 3];
      `SPACE_DATA: w = wsc[`WSC_DATA_LSB +: 3];
      `SPACE_IO:   w = wsc[`WSC_IO_LSB +: 3];
      default:     w = 3'h0;
    endcase
    return w;
  endfunction : sel_wait

  // Region is the top size*256 words of data space; zero means none
  function automatic logic in_global(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0]        size
  );
    return (size != 8'h00) && (addr[15:8] > ~size);
  endfunction : in_global

  //----------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------
  logic [`WSC_USED_BITS-1:0] wsc_ff;
  logic [7:0]                grs_ff;
  logic                      ready_s1_ff;
  logic                      ready_s2_ff;
  logic                      hold_s1_ff;
  logic                      hold_s2_ff;
  logic [DATA_W-1:0]         data_s1_ff;
  logic [DATA_W-1:0]         data_s2_ff;
  bus_state_t                state_ff;
  bus_state_t                nxt_state;
  logic [ADDR_W-1:0]         addr_ff;
  logic [DATA_W-1:0]         wdata_ff;
  logic [1:0]                space_ff;
  logic                      we_ff;
  logic                      global_ff;
  logic                      done_ff;
  logic [DATA_W-1:0]         rdata_ff;
  logic [31:0]               prdata_ff;
  logic                      pslverr_ff;
  logic                      accept;
  logic                      port_write;
  logic                      acc_end;
  logic                      apb_setup;
  logic                      apb_wr;
  logic                      mapped;
  logic [31:0]               status;

  wait_count_if wc ();

  wait_counter u_wait_counter (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .wc        (wc.counter)
  );

  //----------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------
  // Data is staged like READY so the capture lines up with it
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ready_s1_ff <= 1'b0;
      ready_s2_ff <= 1'b0;
      hold_s1_ff  <= 1'b1;
      hold_s2_ff  <= 1'b1;
      data_s1_ff  <= '0;
      data_s2_ff  <= '0;
    end
    else
    begin
      ready_s1_ff <= i_ready;
      ready_s2_ff <= ready_s1_ff;
      hold_s1_ff  <= i_hold_n;
      hold_s2_ff  <= hold_s1_ff;
      data_s1_ff  <= i_ext_data;
      data_s2_ff  <= data_s1_ff;
    end
  end

  //----------------------------------------------------------------
  // Core request decode
  //----------------------------------------------------------------
  // A pending hold blocks new requests so the bus can be released
  assign o_core_ready = (state_ff == ST_IDLE) && hold_s2_ff;
  assign accept       = i_core_req && o_core_ready;
  assign port_write   = accept && i_core_we &&
                        (i_core_space == `SPACE_IO) &&
                        (i_core_addr == `WSC_IO_PORT);
  // end only after count and READY
  assign acc_end      = (state_ff == ST_ACCESS) && wc.expired &&
                        ready_s2_ff;

  assign wc.load     = accept && !port_write;
  assign wc.load_val = sel_wait(i_core_space, i_core_addr, wsc_ff);

  //----------------------------------------------------------------
  // Bus state machine
  //----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (!hold_s2_ff)
          nxt_state = ST_HOLD;
        else if (wc.load)
          nxt_state = ST_ACCESS;
      ST_ACCESS:
        if (acc_end)
          nxt_state = ST_IDLE;
      ST_HOLD:
        if (hold_s2_ff)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  //----------------------------------------------------------------
  // Access latches
  //----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      addr_ff   <= '0;
      wdata_ff  <= '0;
      space_ff  <= `SPACE_PROG;
      we_ff     <= 1'b0;
      global_ff <= 1'b0;
    end
    else if (wc.load)
    begin
      addr_ff   <= i_core_addr;
      wdata_ff  <= i_core_wdata;
      space_ff  <= i_core_space;
      we_ff     <= i_core_we;
      global_ff <= (i_core_space == `SPACE_DATA) &&
                   in_global(i_core_addr, grs_ff);
    end
    else if (acc_end)
      global_ff <= 1'b0;
  end

  //----------------------------------------------------------------
  // Completion and read data
  //----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      done_ff  <= 1'b0;
      rdata_ff <= '0;
    end
    else
    begin
      done_ff <= port_write || acc_end;
      if (acc_end && !we_ff)
        rdata_ff <= data_s2_ff;
    end
  end

  assign o_core_done  = done_ff;
  assign o_core_rdata = rdata_ff;
  assign o_core_hold  = (state_ff == ST_HOLD);

  //----------------------------------------------------------------
  // External pins
  //----------------------------------------------------------------
  // float lines in hold
  assign o_ext_addr_oe    = (state_ff != ST_HOLD);
  assign o_ext_ctrl_oe    = (state_ff != ST_HOLD);
  assign o_ext_data_oe    = (state_ff == ST_ACCESS) && we_ff;
  assign o_ext_addr       = addr_ff;
  assign o_ext_data       = wdata_ff;
  assign o_ext_strobe_n   = (state_ff != ST_ACCESS);
  assign o_ext_read       = !we_ff;
  assign o_ext_prog_sel_n = !((state_ff == ST_ACCESS) &&
                              (space_ff == `SPACE_PROG));
  assign o_ext_data_sel_n = !((state_ff == ST_ACCESS) &&
                              (space_ff == `SPACE_DATA));
  assign o_ext_io_sel_n   = !((state_ff == ST_ACCESS) &&
                              (space_ff == `SPACE_IO));
  assign o_hold_acknowledge_n = (state_ff != ST_HOLD);
  assign o_global_bus_request_n = !((state_ff == ST_ACCESS) && global_ff);

  //----------------------------------------------------------------
  // APB registers
  //----------------------------------------------------------------
  // Zero-wait slave: read data is staged in the setup cycle
  assign apb_setup = i_psel && !i_penable;
  assign apb_wr    = i_psel && i_penable && i_pwrite && mapped;
  assign mapped    = (i_paddr == `WSC_OFFSET) ||
                     (i_paddr == `GRS_OFFSET) ||
                     (i_paddr == `STAT_OFFSET);
  assign o_pready  = 1'b1;
  assign o_prdata  = prdata_ff;
  assign o_pslverr = pslverr_ff;

  always_comb
  begin
    status                 = 32'h0000_0000;
    status[`STAT_BUSY]     = (state_ff == ST_ACCESS);
    status[`STAT_HOLD_ACK] = (state_ff == ST_HOLD);
    status[`STAT_READY]    = ready_s2_ff;
    status[`STAT_GLOBAL]   = !o_global_bus_request_n;
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (apb_setup)
    begin
      pslverr_ff <= !mapped;
      // Wait register is write-only and reads as zero
      if (i_paddr == `GRS_OFFSET)
        prdata_ff <= {24'h00_0000, grs_ff};
      else if (i_paddr == `STAT_OFFSET)
        prdata_ff <= status;
      else
        prdata_ff <= 32'h0000_0000;
    end
  end

  // Port write wins a same-cycle clash with an APB write
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      wsc_ff <= `WSC_RESET;
    else if (port_write)
      wsc_ff <= i_core_wdata[`WSC_USED_BITS-1:0];
    else if (apb_wr && (i_paddr == `WSC_OFFSET))
      wsc_ff <= i_pwdata[`WSC_USED_BITS-1:0];
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      grs_ff <= `GRS_RESET;
    else if (apb_wr && (i_paddr == `GRS_OFFSET))
      grs_ff <= i_pwdata[7:0];
  end

endmodule : ext_bus_wait_state_control

// ===== hw/wait_count_if.sv
// Carrier between the bus controller and its wait-state counter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface wait_count_if;
  import ext_bus_pkg::*;

  logic      load;
  wait_cnt_t load_val;
  logic      expired;

  modport owner   (output load, output load_val, input expired);
  modport counter (input load, input load_val, output expired);

endinterface : wait_count_if

// ===== hw/wait_counter.sv
// Down counter of programmed wait states for one external access.
// Assumes the owner loads it in the cycle the access is accepted.
`timescale 1ns/1ps
module wait_counter
  import ext_bus_pkg::*;
(
  // Clock and reset
  input wire logic     i_sys_clk,
  input wire logic     i_sys_rst,
  // Load and expiry
  wait_count_if.counter wc
);

  wait_cnt_t cnt_ff;

  //----------------------------------------------------------------
  // Count
  //----------------------------------------------------------------
  // count machine cycles
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      cnt_ff <= 3'h0;
    else if (wc.load)
      cnt_ff <= wc.load_val;
    else if (cnt_ff != 3'h0)
      cnt_ff <= cnt_ff - 3'h1;
  end

  // A load overrides a stale zero so a new access never sees it expired
  assign wc.expired = (cnt_ff == 3'h0) && !wc.load;

endmodule : wait_counter
